// ### inc/rcause_pkg.sv
// package: register map, reset values and timing constants for the reset-cause block
package rcause_pkg;
  // register word indices; the apb byte address is index * 4
  localparam logic [7:0] STATUS_IDX = 8'h03;
  localparam logic [7:0] RCAUSE_IDX = 8'h8e;
  localparam logic [7:0] OPTION_IDX = 8'h81;
  localparam logic [7:0] PORTDIR_IDX = 8'h85;
  localparam logic [7:0] INTCTL_IDX = 8'h0b;
  localparam logic [7:0] IRQFLAG_IDX = 8'h0c;
  localparam logic [7:0] IRQEN_IDX = 8'h8c;
  localparam logic [7:0] CFG_IDX = 8'hf0;
  localparam logic [7:0] EVENT_IDX = 8'hf1;
  localparam logic [7:0] PC_IDX = 8'hf2;
  localparam logic [7:0] TIMER_IDX = 8'hf3;
  // field positions
  localparam int BROWNOUT_FLAG_BIT = 0;
  localparam int POWERON_FLAG_BIT = 1;
  localparam int SW_BO_EN_BIT = 4;
  localparam int SLEEP_FLAG_BIT = 3;
  localparam int TIMEOUT_FLAG_BIT = 4;
  localparam int GLOBAL_IRQ_EN_BIT = 7;
  // reset values
  localparam logic [7:0] RCAUSE_IMPL_MASK = 8'h13;
  localparam logic [7:0] STATUS_POR_VAL = 8'h18;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ALL_ZERO = 8'h00;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  // timing
  localparam int OST_PERIODS = 1024;
  localparam int PWRT_MS = 64;
  localparam int CLK_HZ = 50_000_000;
  localparam int PWRT_CYCLES = PWRT_MS * (CLK_HZ / 1000);
  // reset/wake event codes
  typedef enum logic [2:0] {
    EV_NONE = 3'd0, EV_POR = 3'd1, EV_BROWNOUT = 3'd2, EV_DOG_RUN = 3'd3,
    EV_DOG_WAKE = 3'd4, EV_PIN_RUN = 3'd5, EV_PIN_SLEEP = 3'd6, EV_IRQ_WAKE = 3'd7
  } event_t;
  // oscillator configuration
  typedef enum logic [2:0] {
    OSC_SLOW_XTAL = 3'd0, OSC_XTAL = 3'd1, OSC_FAST_XTAL = 3'd2, OSC_RES_CAP = 3'd3,
    OSC_EXT_CLK = 3'd4, OSC_INT = 3'd5
  } osc_t;
  // start-up sequencer states, gray from ST_RUN through ST_PWRT to ST_OST; ST_OST to ST_RUN flips both bits
  typedef enum logic [1:0] {
    ST_RUN = 2'b00, ST_PWRT = 2'b01, ST_OST = 2'b11
  } seq_t;
endpackage

// ### logic/reset_cause_and_init_state.sv
// reset-cause recording, register initialisation and start-up time-out sequencing
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
module reset_cause_and_init_state #(
  parameter int PWRT_COUNT = rcause_pkg::PWRT_CYCLES,
  parameter int OSC_DIV = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] event_code,
  input wire logic event_valid,
  input wire logic [7:0] port_pin_in,
  input wire logic [7:0] analog_sel,
  input wire logic [12:0] pc_next,
  output logic cpu_hold,
  output logic [12:0] pc_load,
  output logic pc_load_valid,
  output logic brownout_detect_en,
  output logic [7:0] port_read
);
  // apb state: all control/status registers
  logic [7:0] status_q, status_d, rcause_q, rcause_d, option_q, option_d, dir_q, dir_d;
  logic [7:0] intctl_q, intctl_d, irqf_q, irqf_d, irqe_q, irqe_d, latch_q, latch_d;
  logic [7:0] cfg_q, cfg_d, wake_src_q, wake_src_d;
  logic [2:0] last_ev_q, last_ev_d;
  logic [12:0] pc_q, pc_d;
  logic pcv_q, pcv_d;
  logic [31:0] prdata_q, prdata_d;
  logic [31:0] tmr_q, tmr_d;
  rcause_pkg::seq_t st_q, st_d;
  // three-flop sync for port pins
  logic [7:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_stable_q, pin_stable_d;
  logic [9:0] idx;
  logic wr, rd, mapped;
  logic [1:0] bo_mode;
  logic pwrt_off, crystal;
  rcause_pkg::osc_t osc;
  rcause_pkg::event_t ev;

  function automatic logic is_crystal(input rcause_pkg::osc_t o);
    return (o == rcause_pkg::OSC_SLOW_XTAL) || (o == rcause_pkg::OSC_XTAL) ||
           (o == rcause_pkg::OSC_FAST_XTAL);
  endfunction

  // cfg register fields: [1:0] brown-out mode, [2] power-up timer off, [5:3] osc mode
  assign bo_mode = cfg_q[1:0];
  assign pwrt_off = cfg_q[2];
  assign osc = rcause_pkg::osc_t'(cfg_q[5:3]);
  assign crystal = is_crystal(osc);
  assign ev = rcause_pkg::event_t'(event_code);
  assign idx = paddr[11:2];
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;

  // decode: index compared against byte address / 4
  always_comb begin
    case (idx[7:0])
      rcause_pkg::STATUS_IDX, rcause_pkg::RCAUSE_IDX, rcause_pkg::OPTION_IDX,
      rcause_pkg::PORTDIR_IDX, rcause_pkg::INTCTL_IDX, rcause_pkg::IRQFLAG_IDX,
      rcause_pkg::IRQEN_IDX, rcause_pkg::CFG_IDX, rcause_pkg::EVENT_IDX,
      rcause_pkg::PC_IDX, rcause_pkg::TIMER_IDX: mapped = (idx[9:8] == 2'b00);
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  // brown-out detector enable depends on mode; mode 00 disables it
  always_comb begin
    case (bo_mode)
      2'b00: brownout_detect_en = 1'b0;
      2'b01: brownout_detect_en = rcause_q[rcause_pkg::SW_BO_EN_BIT];
      2'b10: brownout_detect_en = (st_q == rcause_pkg::ST_RUN);
      default: brownout_detect_en = 1'b1;
    endcase
  end

  // register next-state: events take precedence over software writes in the same cycle
  always_comb begin
    status_d = status_q;
    rcause_d = rcause_q;
    option_d = option_q;
    dir_d = dir_q;
    intctl_d = intctl_q;
    irqf_d = irqf_q;
    irqe_d = irqe_q;
    latch_d = latch_q;
    cfg_d = cfg_q;
    wake_src_d = wake_src_q;
    last_ev_d = last_ev_q;
    pc_d = pc_q;
    pcv_d = 1'b0;
    // software writes; cause flags otherwise hold
    if (wr && mapped) begin
      case (idx[7:0])
        rcause_pkg::STATUS_IDX: status_d = {pwdata[7:5], status_q[4:3], pwdata[2:0]};
        rcause_pkg::RCAUSE_IDX: rcause_d = pwdata[7:0] & rcause_pkg::RCAUSE_IMPL_MASK;
        rcause_pkg::OPTION_IDX: option_d = pwdata[7:0];
        rcause_pkg::PORTDIR_IDX: dir_d = pwdata[7:0];
        rcause_pkg::INTCTL_IDX: intctl_d = pwdata[7:0];
        rcause_pkg::IRQFLAG_IDX: irqf_d = pwdata[7:0];
        rcause_pkg::IRQEN_IDX: irqe_d = pwdata[7:0];
        rcause_pkg::CFG_IDX: cfg_d = pwdata[7:0];
        rcause_pkg::EVENT_IDX: latch_d = pwdata[7:0];
        default: ;
      endcase
    end
    if (event_valid) begin
      last_ev_d = event_code;
      // every reset loads the reset vector; wakes continue at pc_next, an interrupt wake with the global enable set at IRQ_VECTOR
      pcv_d = (ev != rcause_pkg::EV_NONE);
      pc_d = rcause_pkg::RESET_VECTOR;
      if (ev == rcause_pkg::EV_DOG_WAKE || ev == rcause_pkg::EV_IRQ_WAKE) begin
        pc_d = pc_next;
        if (ev == rcause_pkg::EV_IRQ_WAKE && intctl_q[rcause_pkg::GLOBAL_IRQ_EN_BIT]) begin
          pc_d = rcause_pkg::IRQ_VECTOR;
        end
      end else if (ev != rcause_pkg::EV_NONE) begin
        // reset-state registers for all real resets
        option_d = rcause_pkg::ALL_ONES;
        dir_d = rcause_pkg::ALL_ONES;
        intctl_d = rcause_pkg::ALL_ZERO;
        irqf_d = rcause_pkg::ALL_ZERO;
        irqe_d = rcause_pkg::ALL_ZERO;
        status_d[7:5] = 3'b000;
      end
      unique case (ev)
        rcause_pkg::EV_POR: begin
          status_d = rcause_pkg::STATUS_POR_VAL;
          rcause_d = 8'h10;
          latch_d = rcause_pkg::ALL_ZERO; // undefined, zero chosen
        end
        rcause_pkg::EV_BROWNOUT: begin
          status_d[4:3] = 2'b11;
          rcause_d[rcause_pkg::BROWNOUT_FLAG_BIT] = 1'b0;
          rcause_d[rcause_pkg::SW_BO_EN_BIT] = 1'b1;
        end
        rcause_pkg::EV_DOG_RUN: status_d[rcause_pkg::TIMEOUT_FLAG_BIT] = 1'b0;
        rcause_pkg::EV_DOG_WAKE: status_d[4:3] = 2'b00;
        rcause_pkg::EV_PIN_SLEEP: status_d[4:3] = 2'b10;
        rcause_pkg::EV_IRQ_WAKE: begin
          status_d[4:3] = 2'b10;
          irqf_d = irqf_q | wake_src_d; // sets the flags of all sources enabled in wake_src_q
        end
        default: ; // pin reset while running: flags unchanged
      endcase
    end
    // wake-source latch mirrors irq enables; flags that caused wake come from software model
    wake_src_d = irqe_d;
  end

  // start-up time-out sequencer
  always_comb begin
    st_d = st_q;
    tmr_d = (tmr_q == 32'h0000_0000) ? tmr_q : tmr_q - 32'h0000_0001;
    if (event_valid && (ev == rcause_pkg::EV_POR || ev == rcause_pkg::EV_BROWNOUT)) begin
      if (!pwrt_off) begin
        st_d = rcause_pkg::ST_PWRT;
        tmr_d = 32'(PWRT_COUNT);
      end else if (crystal) begin
        st_d = rcause_pkg::ST_OST;
        tmr_d = 32'(rcause_pkg::OST_PERIODS * OSC_DIV);
      end
    end else if (event_valid && crystal &&
                 (ev == rcause_pkg::EV_DOG_WAKE || ev == rcause_pkg::EV_IRQ_WAKE)) begin
      st_d = rcause_pkg::ST_OST; // wake waits 1024 periods only
      tmr_d = 32'(rcause_pkg::OST_PERIODS * OSC_DIV);
    end else if (tmr_q <= 32'h0000_0001) begin
      unique case (st_q)
        rcause_pkg::ST_PWRT: begin
          st_d = crystal ? rcause_pkg::ST_OST : rcause_pkg::ST_RUN;
          tmr_d = crystal ? 32'(rcause_pkg::OST_PERIODS * OSC_DIV) : 32'h0000_0000;
        end
        rcause_pkg::ST_OST: st_d = rcause_pkg::ST_RUN;
        rcause_pkg::ST_RUN: st_d = rcause_pkg::ST_RUN;
      endcase
    end
  end

  // analog-selected pins read zero
  assign pin_stable_d = (pin_s2_q == pin_s3_q) ? pin_s3_q : pin_stable_q;
  assign port_read = pin_stable_q & ~analog_sel;
  assign cpu_hold = (st_q != rcause_pkg::ST_RUN);
  assign pc_load = pc_q;
  assign pc_load_valid = pcv_q;

  // read mux, captured in setup phase so data stands during access
  always_comb begin
    prdata_d = prdata_q;
    if (rd) begin
      prdata_d = 32'h0000_0000;
      case (idx[7:0])
        rcause_pkg::STATUS_IDX: prdata_d[7:0] = status_q;
        rcause_pkg::RCAUSE_IDX: prdata_d[7:0] = rcause_q & rcause_pkg::RCAUSE_IMPL_MASK;
        rcause_pkg::OPTION_IDX: prdata_d[7:0] = option_q;
        rcause_pkg::PORTDIR_IDX: prdata_d[7:0] = dir_q;
        rcause_pkg::INTCTL_IDX: prdata_d[7:0] = intctl_q;
        rcause_pkg::IRQFLAG_IDX: prdata_d[7:0] = irqf_q;
        rcause_pkg::IRQEN_IDX: prdata_d[7:0] = irqe_q;
        rcause_pkg::CFG_IDX: prdata_d[7:0] = cfg_q;
        rcause_pkg::EVENT_IDX: prdata_d[10:0] = {last_ev_q, latch_q};
        rcause_pkg::PC_IDX: prdata_d[12:0] = pc_q;
        rcause_pkg::TIMER_IDX: prdata_d = {st_q, tmr_q[29:0]};
        default: ;
      endcase
      if (idx[9:8] != 2'b00) begin
        prdata_d = 32'h0000_0000;
      end
    end
  end
  assign prdata = prdata_q;

  // register stage; reset loads the power-on register values, but the sequencer starts in ST_RUN with no hold
  always_ff @(posedge clk) begin
    pin_s1_q <= port_pin_in;
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
    if (reset) begin
      status_q <= rcause_pkg::STATUS_POR_VAL;
      rcause_q <= 8'h10;
      option_q <= rcause_pkg::ALL_ONES;
      dir_q <= rcause_pkg::ALL_ONES;
      intctl_q <= rcause_pkg::ALL_ZERO;
      irqf_q <= rcause_pkg::ALL_ZERO;
      irqe_q <= rcause_pkg::ALL_ZERO;
      latch_q <= rcause_pkg::ALL_ZERO;
      cfg_q <= rcause_pkg::ALL_ZERO;
      wake_src_q <= rcause_pkg::ALL_ZERO;
      last_ev_q <= 3'b000;
      pc_q <= rcause_pkg::RESET_VECTOR;
      pcv_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      tmr_q <= 32'h0000_0000;
      st_q <= rcause_pkg::ST_RUN;
      pin_stable_q <= rcause_pkg::ALL_ZERO;
    end else begin
      status_q <= status_d;
      rcause_q <= rcause_d;
      option_q <= option_d;
      dir_q <= dir_d;
      intctl_q <= intctl_d;
      irqf_q <= irqf_d;
      irqe_q <= irqe_d;
      latch_q <= latch_d;
      cfg_q <= cfg_d;
      wake_src_q <= wake_src_d;
      last_ev_q <= last_ev_d;
      pc_q <= pc_d;
      pcv_q <= pcv_d;
      prdata_q <= prdata_d;
      tmr_q <= tmr_d;
      st_q <= st_d;
      pin_stable_q <= pin_stable_d;
    end
  end
endmodule

// ### verif/reset_cause_and_init_state_assertions.sv
// checker: bus and reset-cause timing properties seen at the block's ports
`timescale 1ns/1ns
module reset_cause_and_init_state_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] event_code,
  input wire logic event_valid,
  input wire logic [7:0] analog_sel,
  input wire logic [12:0] pc_next,
  input wire logic [12:0] pc_load,
  input wire logic pc_load_valid,
  input wire logic [7:0] port_read
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // every reset event restarts the program at the reset vector
  property p_pc_reset;
    event_valid && event_code inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6}
      |=> pc_load_valid && pc_load == 13'h0000;
  endproperty
  a_pc_reset: assert property (p_pc_reset) else $error("reset vector not loaded");
  property p_pc_wake;
    event_valid && event_code == 3'h4 |=> pc_load_valid && pc_load == $past(pc_next);
  endproperty
  a_pc_wake: assert property (p_pc_wake) else $error("watchdog wake pc wrong");
  // interrupt wake either continues or takes the vector, depending on the global enable
  property p_pc_irq;
    event_valid && event_code == 3'h7
      |=> pc_load_valid && (pc_load == 13'h0004 || pc_load == $past(pc_next));
  endproperty
  a_pc_irq: assert property (p_pc_irq) else $error("interrupt wake pc wrong");
  property p_valid_cause;
    pc_load_valid |-> $past(event_valid);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("pc load without event");
  property p_analog;
    (port_read & analog_sel) == 8'h00;
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin reads nonzero");
  property p_err_idle;
    !(psel && penable) |-> !pslverr;
  endproperty
  a_err_idle: assert property (p_err_idle) else $error("error outside access");
  property p_err_mapped;
    psel && penable && paddr == {2'b00, rcause_pkg::RCAUSE_IDX, 2'b00} |-> !pslverr && pready;
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("power-control access refused");
  // read data only moves after a read setup, so flags stay visible
  property p_rdata_hold;
    !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule

bind reset_cause_and_init_state reset_cause_and_init_state_chk u_chk (.clk(clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .event_code(event_code), .event_valid(event_valid),
  .analog_sel(analog_sel), .pc_next(pc_next), .pc_load(pc_load),
  .pc_load_valid(pc_load_valid), .port_read(port_read));

// ### verif/tb_top.sv
// testbench: register values, start-up hold lengths and reset-cause flags
`timescale 1ns/1ns
module tb_top;
  logic clk, reset, psel, penable, pwrite, event_valid, pready, pslverr, cpu_hold, err;
  logic pc_load_valid, brownout_detect_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] event_code, ev;
  logic [7:0] port_pin_in, analog_sel, port_read, st, pc, opt, ic, v, sl;
  logic [12:0] pc_next, pc_load, pn, epc;
  integer failures = 0, samples_checked = 0, cycles = 0, seed = 32'h01b6_737b, n, i;
  localparam int PWRT = 20;
  localparam int OST = rcause_pkg::OST_PERIODS * 4;
  localparam logic [7:0] RI [7] = '{8'h03, 8'h8e, 8'h81, 8'h85, 8'h0b, 8'h0c, 8'h8c};
  localparam logic [7:0] RE [7] = '{8'h18, 8'h10, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
  // cfg, power-control, expected detector enable
  localparam logic [7:0] BC [5] = '{8'h00, 8'h01, 8'h01, 8'h03, 8'h02};
  localparam logic [7:0] BP [5] = '{8'h10, 8'h10, 8'h00, 8'h00, 8'h00};
  localparam logic BE [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  // cfg, event, expected hold cycles
  localparam logic [7:0] HC [6] = '{8'h18, 8'h08, 8'h0c, 8'h1c, 8'h08, 8'h20};
  localparam logic [2:0] HE [6] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h4, 3'h5};
  localparam int HN [6] = '{PWRT, PWRT + OST, OST, 0, OST, 0};

  reset_cause_and_init_state #(.PWRT_COUNT(PWRT), .OSC_DIV(4)) DUT (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_code(event_code),
    .event_valid(event_valid), .port_pin_in(port_pin_in), .analog_sel(analog_sel),
    .pc_next(pc_next), .cpu_hold(cpu_hold), .pc_load(pc_load),
    .pc_load_valid(pc_load_valid), .brownout_detect_en(brownout_detect_en),
    .port_read(port_read));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // a hang ends the run as a failure rather than spinning forever
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= {2'b00, idx, 2'b00}; pwdata <= {24'h0000_00, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // step off the edge so callers see the write's effect, not the old value
    #1;
  endtask
  // one-cycle event pulse, then pc check and length of the start-up hold
  task automatic fire(input logic [2:0] e, input logic [12:0] p);
    @(posedge clk);
    event_code <= e; event_valid <= 1'b1;
    @(posedge clk);
    event_valid <= 1'b0;
    #1;
    chk("pc_load_valid", 32'h1, {31'h0, pc_load_valid});
    chk("pc_load", {19'h0, p}, {19'h0, pc_load});
    n = 0;
    while (cpu_hold === 1'b1 && n < 6000) begin
      n++;
      @(posedge clk);
      #1;
    end
  endtask
  function automatic logic [7:0] st_f(input logic [2:0] e, input logic [7:0] s);
    case (e)
      3'h1: return 8'h18;
      3'h2: return (s & 8'h07) | 8'h18;
      3'h3: return s & 8'h0f;
      3'h4: return s & 8'he7;
      3'h5: return s & 8'h1f;
      3'h6: return (s & 8'h07) | 8'h10;
      default: return (s & 8'he7) | 8'h10;
    endcase
  endfunction

  initial begin
    {psel, penable, pwrite, event_valid, event_code, paddr, pwdata} = '0;
    port_pin_in = 8'h00; analog_sel = 8'h00; pc_next = 13'h0123; reset = 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 7; i++) begin
      apb(1'b0, RI[i], 8'h00);
      chk("reset_value", {24'h0000_00, RE[i]}, rd);
    end
    apb(1'b0, 8'h40, 8'h00);
    chk("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b1, 8'h8e, 8'hff);
    apb(1'b0, 8'h8e, 8'h00);
    chk("reset_cause_reg_mask", 32'h13, rd);
    apb(1'b1, 8'h03, 8'h00);
    apb(1'b0, 8'h03, 8'h00);
    chk("status_ro", 32'h18, rd);
    for (i = 0; i < 5; i++) begin
      apb(1'b1, 8'hf0, BC[i]);
      apb(1'b1, 8'h8e, BP[i]);
      chk("bo_enable", {31'h0, BE[i]}, {31'h0, brownout_detect_en});
    end
    for (i = 0; i < 6; i++) begin
      apb(1'b1, 8'hf0, HC[i]);
      fire(HE[i], (HE[i] == 3'h4) ? pc_next : 13'h0000);
      chk("hold_cycles", HN[i], n);
    end
    // second reset mid-run gives a known baseline for the flag model
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    st = 8'h18;
    apb(1'b1, 8'hf0, 8'h18);
    for (i = 0; i < 14; i++) begin
      v = $random(seed); apb(1'b1, 8'h03, v); st = (v & 8'he7) | (st & 8'h18);
      v = $random(seed); apb(1'b1, 8'h8e, v); pc = v & 8'h13;
      opt = $random(seed); apb(1'b1, 8'h81, opt);
      ic = $random(seed); apb(1'b1, 8'h0b, ic);
      pn = $random(seed); pc_next <= pn;
      ev = (i < 7) ? 3'(i + 1) : 3'(1 + {$random(seed)} % 7);
      epc = (ev == 3'h7 && ic[7]) ? 13'h0004 : ((ev inside {3'h4, 3'h7}) ? pn : 13'h0000);
      fire(ev, epc);
      st = st_f(ev, st);
      pc = (ev == 3'h1) ? 8'h10 : ((ev == 3'h2) ? ((pc & 8'h02) | 8'h10) : pc);
      apb(1'b0, 8'h03, 8'h00); chk("status", {24'h0000_00, st}, rd);
      apb(1'b0, 8'h8e, 8'h00); chk("reset_cause_reg", {24'h0000_00, pc}, rd);
      v = (ev inside {3'h4, 3'h7}) ? opt : 8'hff;
      apb(1'b0, 8'h81, 8'h00); chk("option", {24'h0000_00, v}, rd);
      v = (ev inside {3'h4, 3'h7}) ? ic : 8'h00;
      apb(1'b0, 8'h0b, 8'h00); chk("intctl", {24'h0000_00, v}, rd);
    end
    for (i = 0; i < 4; i++) begin
      v = $random(seed); sl = (i == 0) ? 8'hff : 8'($random(seed));
      port_pin_in <= v; analog_sel <= sl;
      repeat (6) @(posedge clk);
      #1;
      chk("port_read", {24'h0000_00, v & ~sl}, {24'h0000_00, port_read});
    end
    report_and_stop();
  end
endmodule
